//--- inc/sfd_defs.svh
`ifndef SFD_DEFS_SVH
`define SFD_DEFS_SVH
`define SFD_OFF_CTRL     12'h000
`define SFD_OFF_CMD      12'h004
`define SFD_OFF_STAT     12'h008
`define SFD_OFF_ERR      12'h00c
`define SFD_OFF_ISTAT    12'h010
`define SFD_OFF_IMASK    12'h014
`define SFD_BUF_SEL      2'b01
`define SFD_CTRL_MASTER  0
`define SFD_CTRL_FIXED   1
`define SFD_CTRL_INV     2
`define SFD_CTRL_CPHA    3
`define SFD_CTRL_SEL_LSB 4
`define SFD_CTRL_RST     7'h08
`define SFD_CMD_START    0
`define SFD_CMD_ABORT    1
`define SFD_CMD_LEN_LSB  8
`define SFD_ERR_MODE     8'h10
`define SFD_ERR_OVR      8'h20
`define SFD_IRQ_IN       0
`define SFD_IRQ_OUT      1
`define SFD_IRQ_ERR      2
`define SFD_DIV_BASE     8
`endif

//--- inc/sfd_if.sv
`timescale 1ns/1ns
`default_nettype none
interface sfd_if;
  logic       master;
  logic       cpha;
  logic       cpol;
  logic       tick;
  logic       lead;
  logic       trail;
  logic       active;
  logic       din;
  logic       flush;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  logic       rx_strobe;
  logic [7:0] rx_data;
  logic       idle;
  logic       dout;
  logic       sck;
  modport ctl (output master, cpha, cpol, tick, lead, trail, active, din,
               output flush, tx_valid, tx_data,
               input  tx_ready, rx_strobe, rx_data, idle, dout, sck);
  modport eng (input  master, cpha, cpol, tick, lead, trail, active, din,
               input  flush, tx_valid, tx_data,
               output tx_ready, rx_strobe, rx_data, idle, dout, sck);
endinterface : sfd_if
`default_nettype wire

//--- inc/sfd_pkg.sv
package sfd_pkg;
  typedef enum logic [1:0] {
    SFD_IDLE  = 2'b00,
    SFD_FEED  = 2'b01,
    SFD_DRAIN = 2'b11
  } sfd_state_t;
  typedef logic [7:0] sfd_byte_t;
endpackage : sfd_pkg

//--- rtl/sfd_clkdiv.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfd_defs.svh"
module sfd_clkdiv #(
  parameter int unsigned BASE = `SFD_DIV_BASE
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Control
  input  wire logic       en_i,
  input  wire logic [2:0] sel_i,
  // Half bit period enable
  output logic            tick_o
);
  logic [15:0] cnt_r;
  logic [15:0] lim_w;
  logic        tick_r;

  // Half period is BASE shifted by the selection
  assign lim_w  = 16'(BASE << sel_i) - 16'h1;
  assign tick_o = tick_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r  <= 16'h0;
      tick_r <= 1'b0;
    end else if (!en_i) begin
      cnt_r  <= 16'h0;
      tick_r <= 1'b0;
    end else if (cnt_r >= lim_w) begin
      cnt_r  <= 16'h0;
      tick_r <= 1'b1;
    end else begin
      cnt_r  <= cnt_r + 16'h1;
      tick_r <= 1'b0;
    end
  end

  tick_gap_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tick_r && en_i |=> !tick_r)
    else $error("divider ticks on consecutive cycles");
endmodule : sfd_clkdiv
`default_nettype wire

//--- rtl/sfd_shifter.sv
`timescale 1ns/1ns
`default_nettype none
module sfd_shifter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Engine side
  sfd_if.eng       bus
);
  logic [7:0] sh_r;
  logic [7:0] rx_r;
  logic [7:0] tdr_r;
  logic [7:0] rxd_r;
  logic [3:0] edge_r;
  logic       tdr_v_r;
  logic       sh_v_r;
  logic       dout_r;
  logic       sck_r;
  logic       stb_r;
  logic       go_w;
  logic       lead_w;
  logic       trail_w;
  logic       last_w;
  logic       load_w;

  assign go_w = sh_v_r & (bus.master ? bus.tick
                                     : bus.active & (bus.lead | bus.trail));
  assign lead_w  = go_w & (bus.master ? ~edge_r[0] : bus.lead);
  assign trail_w = go_w & (bus.master ? edge_r[0] : bus.trail);
  assign last_w  = trail_w & (edge_r == 4'hf);
  // Holding register plus shift register: two bytes ahead
  assign load_w  = tdr_v_r & (~sh_v_r | last_w);
  assign bus.tx_ready  = ~tdr_v_r;
  assign bus.idle      = ~sh_v_r & ~tdr_v_r;
  assign bus.dout      = dout_r;
  assign bus.sck       = sck_r;
  assign bus.rx_strobe = stb_r;
  assign bus.rx_data   = rxd_r;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tdr_v_r <= 1'b0;
      tdr_r   <= 8'h0;
    end else if (bus.flush) begin
      tdr_v_r <= 1'b0;
    end else if (bus.tx_valid && !tdr_v_r) begin
      tdr_v_r <= 1'b1;
      tdr_r   <= bus.tx_data;
    end else if (load_w) begin
      tdr_v_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_r   <= 8'h0;
      rx_r   <= 8'h0;
      edge_r <= 4'h0;
      sh_v_r <= 1'b0;
      dout_r <= 1'b0;
    end else if (bus.flush) begin
      sh_v_r <= 1'b0;
      edge_r <= 4'h0;
    end else begin
      // Deselect drops a half shifted byte position
      if (!bus.master && !bus.active) begin
        edge_r <= 4'h0;
      end
      if (lead_w) begin
        edge_r <= edge_r + 4'h1;
        if (bus.cpha) begin
          dout_r <= sh_r[7];
          sh_r   <= {sh_r[6:0], 1'b0};
        end else begin
          rx_r <= {rx_r[6:0], bus.din};
        end
      end
      if (trail_w) begin
        edge_r <= edge_r + 4'h1;
        if (bus.cpha) begin
          rx_r <= {rx_r[6:0], bus.din};
        end else begin
          dout_r <= sh_r[6];
          sh_r   <= {sh_r[6:0], 1'b0};
        end
      end
      if (load_w) begin
        sh_r   <= tdr_r;
        sh_v_r <= 1'b1;
        edge_r <= 4'h0;
        if (!bus.cpha) begin
          dout_r <= tdr_r[7];
        end
      end else if (last_w) begin
        sh_v_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stb_r <= 1'b0;
      rxd_r <= 8'h0;
      sck_r <= 1'b1;
    end else begin
      stb_r <= last_w & ~bus.flush;
      if (last_w) begin
        rxd_r <= bus.cpha ? {rx_r[6:0], bus.din} : rx_r;
      end
      if (!bus.master || !sh_v_r || bus.flush) begin
        sck_r <= bus.cpol;
      end else if (lead_w || trail_w) begin
        sck_r <= ~sck_r;
      end
    end
  end
endmodule : sfd_shifter
`default_nettype wire

//--- rtl/sfd_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfd_defs.svh"
// Operation
// - Pin directions follow master, slave, fixed mode
// - One buffer, received byte overwrites sent byte
// - Counts start equal; two bytes preloaded
// - Early slave stop leaves bytes committed
// - Start returns at once; poll status
// - Output done once all bytes left
// - Received count qualifies completion
// - Cumulative error code: 0x10 mode, 0x20 overrun
// - Error cleared on start and on read
// - Abort stops; received count stays exact
// - Up to 255 bytes per transfer
// - Master bit rate divisor selection 0..7
// - Clock idles high unless inverted
// - Phase picks present and latch edges
module sfd_top
  import sfd_pkg::*;
#(
  parameter int unsigned DEPTH    = 255,
  parameter int unsigned DIV_BASE = `SFD_DIV_BASE
) (
  // Clock and reset
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Serial pins
  input  wire logic        SCK_I,
  output logic             SCK_O,
  output logic             SCK_OE_O,
  input  wire logic        PIN_B_I,
  output logic             PIN_B_O,
  output logic             PIN_B_OE_O,
  input  wire logic        PIN_C_I,
  output logic             PIN_C_O,
  output logic             PIN_C_OE_O,
  input  wire logic        SEL_N_I,
  // Interrupt
  output logic             IRQ_O
);
  sfd_if bif ();

  sfd_state_t st_r;
  sfd_byte_t  mem [0:DEPTH-1];
  sfd_byte_t  len_r;
  sfd_byte_t  tx_cnt_r;
  sfd_byte_t  rx_cnt_r;
  sfd_byte_t  err_r;
  sfd_byte_t  rhr_r;
  logic [6:0]  ctrl_r;
  logic [2:0]  ist_r;
  logic [2:0]  imask_r;
  logic [31:0] prdata_r;
  logic [31:0] rdata_w;
  logic [3:0]  pin_w;
  logic [3:0]  filt_w;
  logic [2:0]  ev_w;
  logic [7:0]  buf_idx_w;
  sfd_byte_t   start_len_w;
  logic        rhr_v_r, out_done_r, flush_r, irq_r, sck_p_r;
  logic        pready_r, pslverr_r, hit_w, buf_hit_w;
  logic        setup_w, acc_w, wr_w, cmd_wr_w, rd_err_w, rd_ist_w;
  logic        start_w, abort_w, mfault_w, stop_w, ovr_w;
  logic        push_w, move_w, in_done_w, out_set_w;
  logic        sck_o_r, sck_oe_r, pb_o_r, pb_oe_r, pc_o_r, pc_oe_r;

  assign pin_w = {SEL_N_I, PIN_C_I, PIN_B_I, SCK_I};
  for (genvar gi = 0; gi < 4; gi++) begin : g_sync
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic f_r;
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        s3_r <= 1'b1;
        f_r  <= 1'b1;
      end else begin
        s1_r <= pin_w[gi];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          f_r <= s3_r;
        end
      end
    end
    assign filt_w[gi] = f_r;
  end

  // APB decode; one wait state, side effects at the completing edge
  assign setup_w   = PSEL_I & PENABLE_I & ~pready_r;
  assign acc_w     = PSEL_I & PENABLE_I & pready_r;
  assign wr_w      = acc_w & PWRITE_I & hit_w;
  assign cmd_wr_w  = wr_w & (PADDR_I == `SFD_OFF_CMD);
  assign rd_err_w  = acc_w & ~PWRITE_I & (PADDR_I == `SFD_OFF_ERR);
  assign rd_ist_w  = acc_w & ~PWRITE_I & (PADDR_I == `SFD_OFF_ISTAT);
  assign buf_idx_w = PADDR_I[9:2];
  assign buf_hit_w = (PADDR_I[11:10] == `SFD_BUF_SEL) &
                     (32'(buf_idx_w) < DEPTH) & (PADDR_I[1:0] == 2'b00);
  assign start_len_w = PWDATA_I[`SFD_CMD_LEN_LSB +: 8];

  always_comb begin
    rdata_w = 32'h0;
    hit_w   = 1'b1;
    if (buf_hit_w) begin
      rdata_w = {24'h0, mem[buf_idx_w]};
    end else begin
      case (PADDR_I)
        `SFD_OFF_CTRL:  rdata_w = {25'h0, ctrl_r};
        `SFD_OFF_CMD:   rdata_w = {16'h0, len_r, 8'h0};
        `SFD_OFF_STAT:  rdata_w = {8'h0, tx_cnt_r, rx_cnt_r,
                                   6'h0, out_done_r, st_r != SFD_IDLE};
        `SFD_OFF_ERR:   rdata_w = {24'h0, err_r};
        `SFD_OFF_ISTAT: rdata_w = {29'h0, ist_r};
        `SFD_OFF_IMASK: rdata_w = {29'h0, imask_r};
        default:        hit_w   = 1'b0;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0;
    end else begin
      pready_r  <= setup_w;
      pslverr_r <= setup_w & ~hit_w;
      if (setup_w) begin
        prdata_r <= PWRITE_I ? 32'h0 : rdata_w;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_r  <= `SFD_CTRL_RST;
      imask_r <= 3'h0;
    end else if (wr_w && PADDR_I == `SFD_OFF_CTRL) begin
      ctrl_r <= PWDATA_I[6:0];
    end else if (wr_w && PADDR_I == `SFD_OFF_IMASK) begin
      imask_r <= PWDATA_I[2:0];
    end
  end

  // Link side configuration and sampled pins
  assign bif.master = ctrl_r[`SFD_CTRL_MASTER];
  assign bif.cpha   = ctrl_r[`SFD_CTRL_CPHA];
  assign bif.cpol   = ~ctrl_r[`SFD_CTRL_INV];
  assign bif.active = ctrl_r[`SFD_CTRL_FIXED] | ~filt_w[3];
  assign bif.din    = bif.master ? filt_w[1] : filt_w[2];
  assign bif.lead   = bif.cpol ? (~filt_w[0] & sck_p_r)
                               : (filt_w[0] & ~sck_p_r);
  assign bif.trail  = bif.cpol ? (filt_w[0] & ~sck_p_r)
                               : (~filt_w[0] & sck_p_r);
  assign bif.flush    = flush_r;
  assign bif.tx_valid = push_w;
  assign bif.tx_data  = mem[tx_cnt_r];

  sfd_clkdiv #(
    .BASE (DIV_BASE)
  ) u_div (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .en_i    (bif.master & (st_r != SFD_IDLE)),
    .sel_i   (ctrl_r[`SFD_CTRL_SEL_LSB +: 3]),
    .tick_o  (bif.tick)
  );

  sfd_shifter u_shift (
    .clk_i   (MCLK_I),
    .rst_n_i (RST_N_I),
    .bus     (bif)
  );

  // Transfer engine
  assign start_w   = cmd_wr_w & PWDATA_I[`SFD_CMD_START] &
                     (st_r == SFD_IDLE);
  assign abort_w   = cmd_wr_w & PWDATA_I[`SFD_CMD_ABORT] &
                     (st_r != SFD_IDLE);
  assign mfault_w  = bif.master & ~filt_w[3] & (st_r != SFD_IDLE);
  assign stop_w    = abort_w | mfault_w;
  assign ovr_w     = bif.rx_strobe & rhr_v_r & (st_r != SFD_IDLE);
  // Keeps feeding regardless of received content
  assign push_w    = (st_r == SFD_FEED) & bif.tx_ready & ~stop_w;
  assign move_w    = rhr_v_r & ~stop_w & (rx_cnt_r < len_r);
  assign in_done_w = (st_r == SFD_DRAIN) & (rx_cnt_r == len_r) &
                     ~rhr_v_r & ~stop_w;
  assign out_set_w = (st_r == SFD_DRAIN) & bif.idle & ~out_done_r &
                     ~stop_w;
  assign ev_w      = {mfault_w | ovr_w, out_set_w, in_done_w};

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r <= SFD_IDLE;
    end else if (stop_w) begin
      st_r <= SFD_IDLE;
    end else begin
      case (st_r)
        SFD_IDLE: begin
          if (start_w) begin
            st_r <= (start_len_w == 8'h0) ? SFD_DRAIN : SFD_FEED;
          end
        end
        SFD_FEED: begin
          if (push_w && (tx_cnt_r + 8'h1) == len_r) begin
            st_r <= SFD_DRAIN;
          end
        end
        SFD_DRAIN: begin
          if (in_done_w) begin
            st_r <= SFD_IDLE;
          end
        end
        default: st_r <= SFD_IDLE;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      len_r    <= 8'h0;
      tx_cnt_r <= 8'h0;
      rx_cnt_r <= 8'h0;
    end else if (start_w) begin
      len_r    <= start_len_w;
      tx_cnt_r <= 8'h0;
      rx_cnt_r <= 8'h0;
    end else begin
      if (push_w) begin
        tx_cnt_r <= tx_cnt_r + 8'h1;
      end
      if (move_w) begin
        rx_cnt_r <= rx_cnt_r + 8'h1;
      end
    end
  end

  // Buffer has no reset; data only
  always_ff @(posedge MCLK_I) begin
    if (move_w) begin
      mem[rx_cnt_r] <= rhr_r;
    end else if (wr_w && buf_hit_w) begin
      mem[buf_idx_w] <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      rhr_r   <= 8'h0;
      rhr_v_r <= 1'b0;
    end else if (stop_w) begin
      rhr_v_r <= 1'b0;
    end else if (bif.rx_strobe && st_r != SFD_IDLE) begin
      rhr_r   <= bif.rx_data;
      rhr_v_r <= 1'b1;
    end else if (move_w) begin
      rhr_v_r <= 1'b0;
    end
  end

  // Read clear drops only bits already returned, so late sets survive
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      err_r      <= 8'h0;
      ist_r      <= 3'h0;
      out_done_r <= 1'b0;
    end else begin
      if (start_w) begin
        err_r <= 8'h0;
      end else begin
        err_r <= (rd_err_w ? (err_r & ~prdata_r[7:0]) : err_r) |
                 (mfault_w ? `SFD_ERR_MODE : 8'h0) |
                 (ovr_w ? `SFD_ERR_OVR : 8'h0);
      end
      ist_r <= (rd_ist_w ? (ist_r & ~prdata_r[2:0]) : ist_r) | ev_w;
      if (start_w) begin
        out_done_r <= 1'b0;
      end else if (out_set_w) begin
        out_done_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      flush_r  <= 1'b0;
      irq_r    <= 1'b0;
      sck_p_r  <= 1'b1;
      sck_o_r  <= 1'b1;
      sck_oe_r <= 1'b0;
      pb_o_r   <= 1'b0;
      pb_oe_r  <= 1'b0;
      pc_o_r   <= 1'b0;
      pc_oe_r  <= 1'b0;
    end else begin
      flush_r  <= stop_w;
      irq_r    <= |(ist_r & imask_r);
      sck_p_r  <= filt_w[0];
      sck_o_r  <= bif.sck;
      sck_oe_r <= bif.master;
      pb_o_r   <= bif.dout;
      pb_oe_r  <= ~bif.master & bif.active;
      pc_o_r   <= bif.dout;
      pc_oe_r  <= bif.master;
    end
  end

  assign PRDATA_O   = prdata_r;
  assign PREADY_O   = pready_r;
  assign PSLVERR_O  = pslverr_r;
  assign SCK_O      = sck_o_r;
  assign SCK_OE_O   = sck_oe_r;
  assign PIN_B_O    = pb_o_r;
  assign PIN_B_OE_O = pb_oe_r;
  assign PIN_C_O    = pc_o_r;
  assign PIN_C_OE_O = pc_oe_r;
  assign IRQ_O      = irq_r;

  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  preload_two_a: assert property (
    start_w && start_len_w >= 8'h2 && bif.idle |->
      ##[1:5] (tx_cnt_r == 8'h2 && rx_cnt_r == 8'h0))
    else $error("two bytes not preloaded after start");
  start_clear_a: assert property (
    start_w |=> err_r == 8'h0 && tx_cnt_r == 8'h0 && rx_cnt_r == 8'h0)
    else $error("start did not clear counts and error");
  err_readclr_a: assert property (
    rd_err_w && !mfault_w && !ovr_w |=> (err_r & prdata_r[7:0]) == 8'h0)
    else $error("error read did not clear returned bits");
  overrun_code_a: assert property (
    bif.rx_strobe && rhr_v_r && st_r != SFD_IDLE |=> err_r[5])
    else $error("overrun did not set code 0x20");
  mode_fault_a: assert property (
    mfault_w |=> (err_r & `SFD_ERR_MODE) != 8'h0 && st_r == SFD_IDLE)
    else $error("mode fault not coded or not stopped");
  abort_count_a: assert property (
    abort_w |=> st_r == SFD_IDLE ##0 $stable(rx_cnt_r) [*3])
    else $error("received count moved after abort");
  out_before_in_a: assert property (
    in_done_w && len_r != 8'h0 |-> out_done_r)
    else $error("input done before output done");
  done_count_a: assert property (
    (st_r == SFD_DRAIN && !stop_w) ##1 st_r == SFD_IDLE |->
      rx_cnt_r == len_r)
    else $error("transfer ended short of length");
  tx_bound_a: assert property (
    tx_cnt_r <= len_r && rx_cnt_r <= tx_cnt_r)
    else $error("counts out of order");
  master_pins_a: assert property (
    bif.master && $stable(ctrl_r) |=> SCK_OE_O && PIN_C_OE_O && !PIN_B_OE_O)
    else $error("master pin directions wrong");
  irq_level_a: assert property (
    (ist_r & imask_r) != 3'h0 |=> IRQ_O)
    else $error("unmasked status without interrupt");

  master_done_c: cover property (bif.master && in_done_w && len_r > 8'h2);
  slave_done_c:  cover property (!bif.master && in_done_w && len_r > 8'h2);
  abort_c:       cover property (abort_w && rx_cnt_r != 8'h0);
  overrun_c:     cover property (ovr_w);
endmodule : sfd_top
`default_nettype wire

//--- tb/sfd_peer.sv
`timescale 1ns/1ns
`default_nettype none
module sfd_peer (
  // Link
  input  wire logic sck_i,
  input  wire logic din_i,
  input  wire logic cpol_i,
  input  wire logic cpha_i,
  output logic      sck_o,
  output logic      dout_o,
  // Bench
  input  wire logic arm_i
);
  logic [7:0] rx_q [0:7];
  logic [7:0] sh;
  logic [7:0] tx;
  logic [2:0] idx;
  logic [3:0] nb;

  function automatic logic [7:0] pat(input logic [3:0] n);
    return 8'h3c ^ {n, n};
  endfunction : pat

  initial begin
    sck_o  = 1'b1;
    dout_o = 1'b0;
  end

  // Phase 0 needs its first bit out before any edge
  always @(posedge arm_i) begin
    idx    = 3'h0;
    nb     = 4'h0;
    tx     = pat(4'h0);
    dout_o = tx[7];
  end

  // Released line flips so a stale bit cannot pass
  always @(negedge arm_i) begin
    dout_o = ~dout_o;
  end

  always @(sck_i) begin
    if (arm_i === 1'b1) begin
      if ((sck_i !== cpol_i) ^ cpha_i) begin
        sh  = {sh[6:0], din_i};
        idx = idx + 3'h1;
        if (idx == 3'h0) begin
          rx_q[nb[2:0]] = sh;
          nb = nb + 4'h1;
        end
      end else begin
        tx     = pat(nb);
        dout_o = tx[3'h7 - idx];
      end
    end
  end

  // Clock runs only inside a frame
  task automatic frame(input int n);
    repeat (n * 16) begin
      #40;
      sck_o = ~sck_o;
    end
  endtask : frame
endmodule : sfd_peer
`default_nettype wire

//--- tb/sfd_top_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "sfd_defs.svh"
module sfd_top_test import sfd_pkg::*;;
  // Half period must outlast the pin synchroniser lag
  localparam int unsigned BASE = 8;
  logic        clk, rst_n, psel, pen, pwr, sel_n, dev_m, arm, cpol, cpha;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        perr, pready, pslverr, irq;
  logic        sck_o, sck_oe, b_o, b_oe, c_o, c_oe;
  wire logic   sck_w, b_w, c_w, p_sck, p_dout;
  int          errors, num_checks;

  assign sck_w = sck_oe ? sck_o : p_sck;
  assign b_w   = b_oe ? b_o : p_dout;
  assign c_w   = c_oe ? c_o : p_dout;

  sfd_top #(.DIV_BASE(BASE)) u_dut (
    .MCLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .PIN_B_I(b_w), .PIN_B_O(b_o), .PIN_B_OE_O(b_oe),
    .PIN_C_I(c_w), .PIN_C_O(c_o), .PIN_C_OE_O(c_oe),
    .SEL_N_I(sel_n), .IRQ_O(irq)
  );

  sfd_peer u_peer (
    .sck_i(sck_w), .din_i(dev_m ? c_w : b_w), .cpol_i(cpol),
    .cpha_i(cpha), .sck_o(p_sck), .dout_o(p_dout), .arm_i(arm)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic sfd_byte_t pat(input logic [3:0] n);
    return 8'h3c ^ {n, n};
  endfunction : pat

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd   = prdata;
    perr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdx(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rdx

  // Poll only; a start never blocks the bus
  task automatic wait_rx(input logic [7:0] n);
    int k;
    k = 0;
    do begin
      rdx(`SFD_OFF_STAT);
      k++;
    end while (rd[15:8] !== n && k < 6000);
  endtask : wait_rx

  task automatic t_reset;
    rdx(`SFD_OFF_CTRL);
    chk("ctrl reset", 32'h8, rd);
    rdx(12'h7fc);
    chk("unmapped err", 32'h1, {31'h0, perr});
    chk("unmapped data", 32'h0, rd);
    wr(`SFD_OFF_CTRL, 32'ha);
    repeat (2) @(posedge clk);
    chk("fixed roles", 32'h2, {29'h0, sck_oe, b_oe, c_oe});
  endtask : t_reset

  task automatic t_master;
    int h;
    logic lv;
    sfd_byte_t b;
    dev_m <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      cpol = ~s[1];
      cpha = s[0];
      b = 8'h81 ^ s[7:0];
      wr(`SFD_OFF_CTRL, {25'h0, s[2:0], cpha, ~cpol, 2'b01});
      wr(12'h400, {24'h0, b});
      arm <= 1'b1;
      chk("sck idle", {31'h0, cpol}, {31'h0, sck_o});
      wr(`SFD_OFF_CMD, 32'h0101);
      @(sck_o);
      lv = sck_o;
      h = 0;
      do begin
        @(posedge clk);
        #1;
        h++;
      end while (sck_o === lv && h < 1100);
      chk("half period", BASE << s, h);
      wait_rx(8'd1);
      // Busy drops a cycle after the count; look again
      rdx(`SFD_OFF_STAT);
      chk("stat done", 32'h0001_0102, rd);
      rdx(12'h400);
      chk("buf byte", {24'h0, pat(4'h0)}, rd);
      chk("peer byte", {24'h0, b}, {24'h0, u_peer.rx_q[0]});
      arm <= 1'b0;
    end
  endtask : t_master

  task automatic t_slave;
    dev_m <= 1'b0;
    cpol = 1'b1;
    cpha = 1'b1;
    wr(`SFD_OFF_CTRL, 32'h8);
    rdx(`SFD_OFF_ISTAT);
    wr(`SFD_OFF_IMASK, 32'h3);
    wr(12'h400, 32'h5a);
    wr(12'h404, 32'ha7);
    sel_n <= 1'b0;
    arm   <= 1'b1;
    wr(`SFD_OFF_CMD, 32'h0201);
    // Second preload lands a few cycles after the start
    repeat (4) @(posedge clk);
    rdx(`SFD_OFF_STAT);
    chk("stat preload", 32'h0002_0001, rd);
    chk("pin roles", 32'h2, {29'h0, sck_oe, b_oe, c_oe});
    u_peer.frame(2);
    wait_rx(8'd2);
    for (int k = 0; k < 2; k++) begin
      rdx(12'h400 + 12'(4 * k));
      chk("buf byte", {24'h0, pat(k[3:0])}, rd);
      chk("peer byte", {24'h0, k ? 8'ha7 : 8'h5a},
          {24'h0, u_peer.rx_q[k]});
    end
    repeat (2) @(posedge clk);
    chk("irq set", 32'h1, {31'h0, irq});
    rdx(`SFD_OFF_ISTAT);
    chk("istat", 32'h3, rd);
    repeat (3) @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    arm   <= 1'b0;
    sel_n <= 1'b1;
  endtask : t_slave

  // Stop after one byte; two more already sit in the chain
  task automatic t_abort;
    sel_n <= 1'b0;
    arm   <= 1'b1;
    wr(`SFD_OFF_CMD, 32'h0401);
    u_peer.frame(1);
    wait_rx(8'd1);
    chk("stat one in", 32'h0003_0101, rd);
    wr(`SFD_OFF_CMD, 32'h2);
    rdx(`SFD_OFF_STAT);
    chk("rx after abort", 32'h0100, {16'h0, rd[15:8], 7'h0, rd[0]});
    arm   <= 1'b0;
    sel_n <= 1'b1;
  endtask : t_abort

  task automatic t_fault;
    dev_m <= 1'b1;
    wr(`SFD_OFF_CTRL, 32'h9);
    rdx(`SFD_OFF_ISTAT);
    wr(`SFD_OFF_IMASK, 32'h1);
    wr(`SFD_OFF_CMD, 32'h0201);
    sel_n <= 1'b0;
    repeat (8) @(posedge clk);
    rdx(`SFD_OFF_STAT);
    chk("busy after fault", 32'h0, {31'h0, rd[0]});
    chk("irq masked", 32'h0, {31'h0, irq});
    rdx(`SFD_OFF_ERR);
    chk("err mode", 32'h10, rd);
    rdx(`SFD_OFF_ERR);
    chk("err read clear", 32'h0, rd);
    wr(`SFD_OFF_IMASK, 32'h4);
    repeat (2) @(posedge clk);
    chk("irq error", 32'h1, {31'h0, irq});
    wr(`SFD_OFF_CMD, 32'h0101);
    repeat (8) @(posedge clk);
    wr(`SFD_OFF_CTRL, 32'h8);
    wr(`SFD_OFF_CMD, 32'h0001);
    rdx(`SFD_OFF_ERR);
    chk("err start clear", 32'h0, rd);
    sel_n <= 1'b1;
  endtask : t_fault

  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sel_n = 1'b1;
    dev_m = 1'b1;
    arm = 1'b0;
    cpol = 1'b1;
    cpha = 1'b1;
    errors = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_master;
    t_slave;
    t_abort;
    t_fault;
    summarize;
  end

  // About twice the expected run
  initial begin
    #300000;
    errors++;
    summarize;
  end
endmodule : sfd_top_test
`default_nettype wire
